// [spdif_rx_pkg.sv]
`default_nettype none
package spdif_rx_pkg;
   localparam logic [7:0] CS_BASE        = 8'h20;
   localparam logic [7:0] CS_LAST        = 8'h37;
   localparam logic [7:0] REG_BUF_CONF   = 8'h19;
   localparam logic [7:0] REG_CS_SWITCH  = 8'h1B;
   localparam logic [7:0] REG_FLAGS      = 8'h1C;
   localparam logic [7:0] REG_MASK       = 8'h1D;
   localparam logic [7:0] REG_UB_ADDR    = 8'h1E;
   localparam logic [7:0] REG_UB_DATA    = 8'h1F;
   localparam logic [7:0] REG_QSUB_BASE  = 8'h40;
   localparam logic [7:0] REG_QSUB_LAST  = 8'h49;
   localparam int         CONF_SIZE_BIT  = 0;
   localparam int         CONF_MODE_LO   = 1;
   localparam int         CONF_FSEL_BIT  = 3;
   localparam int         FLAG_CSB_BIT   = 0;
   localparam int         FLAG_UB_BIT    = 1;
   localparam int         FLAG_CRC_BIT   = 2;
   localparam int         MASK_UB_BIT    = 1;
   localparam logic [7:0] CONF_RESET     = 8'h00;
   localparam logic [7:0] MASK_RESET     = 8'h00;
   localparam logic [2:0] FLAGS_RESET    = 3'h0;
   localparam int         PRO_BIT        = 0;
   localparam int         UBM_LO         = 12;
   localparam int         CS_CMP_BITS    = 40;
   localparam logic [7:0] CS_FRAME_LAST  = 8'hBF;
   localparam logic [7:0] PRE_Z          = 8'hE8;
   localparam logic [7:0] PRE_X          = 8'hE2;
   localparam logic [7:0] PRE_Y          = 8'hE4;
   localparam logic [6:0] UB_LAST_SMALL  = 7'h2F;
   localparam logic [6:0] UB_LAST_LARGE  = 7'h5F;
   localparam logic [7:0] UB_BANK_OFFS   = 8'h60;
   localparam int         UB_MEM_DEPTH   = 192;
   localparam logic [3:0] IU_ZERO_RUN    = 4'h8;
   localparam logic [2:0] IU_BITS_LAST   = 3'h6;
   localparam logic [6:0] IU_Q_LAST      = 7'h5F;
   localparam int         Q_PAY_BITS     = 80;
   localparam logic [15:0] Q_CRC_POLY    = 16'h1021;

   typedef enum logic [1:0] {
      PRE_NONE  = 2'b00,
      PRE_LEFT  = 2'b01,
      PRE_RIGHT = 2'b10,
      PRE_BLOCK = 2'b11
   } pre_kind_t;

   typedef enum logic [1:0] {
      UM_IGNORE = 2'b00,
      UM_RAW    = 2'b01,
      UM_IU     = 2'b10
   } ub_mode_t;

   typedef enum logic [1:0] {
      UB_IDLE = 2'b00,
      UB_RAW  = 2'b01,
      UB_GAP  = 2'b10,
      UB_UNIT = 2'b11
   } ub_state_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] preamble;
      logic       user;
      logic       status;
   } subframe_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } host_req_t;

   // Either polarity of a preamble counts, the line may be inverted
   function automatic pre_kind_t pre_decode(input logic [7:0] p);
      pre_kind_t k;
      k = PRE_NONE;
      if (p == PRE_Z || p == ~PRE_Z)
         k = PRE_BLOCK;
      else if (p == PRE_X || p == ~PRE_X)
         k = PRE_LEFT;
      else if (p == PRE_Y || p == ~PRE_Y)
         k = PRE_RIGHT;
      return k;
   endfunction

   // Payload first in arrival order, check word sent inverted
   function automatic logic crc_ok(input logic [95:0] q);
      logic [15:0] c;
      logic        fb;
      c = 16'h0000;
      for (int i = 95; i >= 96 - Q_PAY_BITS; i--)
      begin
         fb = c[15] ^ q[i];
         c = {c[14:0], 1'b0} ^ (fb ? Q_CRC_POLY : 16'h0000);
      end
      return c == ~q[15:0];
   endfunction

   function automatic logic [7:0] bank_addr(input logic       bank,
                                            input logic [6:0] a);
      return {1'b0, a} + (bank ? UB_BANK_OFFS : 8'h00);
   endfunction
endpackage
`default_nettype wire

// [ub_mem.sv]
`timescale 1ns/1ps
`default_nettype none
module ub_mem
   import spdif_rx_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic       we,
   input  wire logic [7:0] waddr,
   input  wire logic [7:0] wdata,
   input  wire logic [7:0] raddr,
   output logic      [7:0] rdata
);
   logic [7:0] mem [0:UB_MEM_DEPTH-1];

   always_ff @(posedge clk_sys)
   begin
      if (we)
         mem[waddr] <= wdata;
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         rdata <= 8'h00;
      else
         rdata <= mem[raddr];
   end
endmodule
`default_nettype wire

// [spdif_rx_buffers.sv]
// What this block does
// - Each channel's status block forms 192 bits, read as 24 bytes.
// - Status bytes occupy register addresses 0x20 through 0x37.
// - Status collects in a working copy; host copy updates after both.
// - Both 192-bit blocks kept; select bit picks channel for reads.
// - User bytes read indirectly: write offset, then read data.
// - Each data-register read steps the offset by one, or back to zero from the last byte.
// - Status flag on every block, or only if first five bytes change.
// - Size bit picks 384 or 768 user bits, block starting at Z.
// - Config 00 ignores user bits; 01 fills, swaps when full.
// - Config 10: professional uses byte 1 bits 7..4, else units.
// - Automatic codes 0000 ignore, 0100/1100 raw, 1000 raw small.
// - Buffer full sets the user flag when its mask is set.
// - Unit mode drops stuffing zeros, stores only the units.
// - More than eight zeros ends a message; commit and restart.
// - Each unit stored as byte: 1 then Q R S T U V W.
// - After 96 units, Q bits gathered; first 10 bytes readable.
// - First 80 Q bits are payload, last 16 are its check.
// - Check mismatch sets sticky flag, cleared by reading it.
// - Block-start preamble 11101000 or complement marks left and start.
// - One user and one status bit per subframe; 192-frame blocks.
`timescale 1ns/1ps
`default_nettype none
module spdif_rx_buffers
   import spdif_rx_pkg::*;
(
   input  wire logic      clk_sys,
   input  wire logic      rst,
   input  wire subframe_t sub,
   input  wire host_req_t host,
   output logic [7:0]     rd_data,
   output logic           rd_ack,
   output logic           status_block_flag,
   output logic           user_buffer_full_flag,
   output logic           subcode_crc_fail_flag
);
   pre_kind_t    kind;
   logic         sf_left;
   logic         sf_right;
   logic         sf_z;
   logic         cs_sync_r;
   logic [7:0]   fc_r;
   logic [191:0] cs_work_a_r;
   logic [191:0] cs_work_b_r;
   logic [191:0] cs_host_a_r;
   logic [191:0] cs_host_b_r;
   logic [191:0] cs_new_b;
   logic         cs_done;
   logic         cs_changed;
   logic [7:0]   conf_r;
   logic         sel_r;
   logic [7:0]   mask_r;
   logic [2:0]   flags_r;
   logic [2:0]   flags_nxt;
   logic [6:0]   ub_addr_r;
   logic [6:0]   ub_addr_nxt;
   ub_state_t    st_r;
   logic [6:0]   bsh_r;
   logic [2:0]   bcnt_r;
   logic [6:0]   waddr_r;
   logic [3:0]   zcnt_r;
   logic [6:0]   iu_cnt_r;
   logic [95:0]  q_sh_r;
   logic [79:0]  q_buf_r;
   logic         wbank_r;
   logic         wbank_nxt;
   ub_mode_t     mode;
   logic [1:0]   cfg;
   logic         pro;
   logic [3:0]   ubm;
   logic         auto_raw;
   logic         size_large;
   logic [6:0]   ub_last;
   logic [6:0]   rd_last;
   logic         st_mismatch;
   logic         raw_byte;
   logic         raw_full;
   logic         iu_done;
   logic         iu_byte;
   logic         q_full;
   logic         crc_bad;
   logic         zero_run_end;
   logic         ub_swap;
   logic         mem_we;
   logic [7:0]   mem_wdata;
   logic [7:0]   mem_q;
   logic         rd_flags;
   logic         rd_ubd;
   logic         in_cs;
   logic         in_q;
   logic [4:0]   cs_idx;
   logic [3:0]   q_idx;
   logic [6:0]   q_hi;
   logic [191:0] cs_view;
   logic [7:0]   cs_byte;
   logic [7:0]   q_byte;
   logic [7:0]   rd_mux;
   logic [7:0]   rd_data_r;
   logic         rd_ack_r;

   assign kind     = pre_decode(sub.preamble);
   assign sf_z     = sub.valid && kind == PRE_BLOCK;
   assign sf_left  = sub.valid && (kind == PRE_LEFT || kind == PRE_BLOCK);
   assign sf_right = sub.valid && kind == PRE_RIGHT;

   // block complete on last right bit
   assign cs_done    = sf_right && cs_sync_r && fc_r == CS_FRAME_LAST;
   assign cs_new_b   = {sub.status, cs_work_b_r[190:0]};
   assign cs_changed =
      cs_work_a_r[CS_CMP_BITS-1:0] != cs_host_a_r[CS_CMP_BITS-1:0] ||
      cs_new_b[CS_CMP_BITS-1:0] != cs_host_b_r[CS_CMP_BITS-1:0];

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         cs_sync_r   <= 1'b0;
         fc_r        <= 8'h00;
         cs_work_a_r <= '0;
         cs_work_b_r <= '0;
      end
      else
      begin
         if (sf_z)
         begin
            cs_sync_r      <= 1'b1;
            fc_r           <= 8'h00;
            cs_work_a_r[0] <= sub.status;
         end
         else if (sf_left && cs_sync_r)
            cs_work_a_r[fc_r] <= sub.status;
         if (sf_right && cs_sync_r)
         begin
            cs_work_b_r[fc_r] <= sub.status;
            fc_r              <= fc_r + 8'h01;
            // Wait for a fresh Z so a lost block start cannot skew bits
            if (cs_done)
               cs_sync_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         cs_host_a_r <= '0;
         cs_host_b_r <= '0;
      end
      else if (cs_done)
      begin
         cs_host_a_r <= cs_work_a_r;
         cs_host_b_r <= cs_new_b;
      end
   end

   assign cfg      = conf_r[CONF_MODE_LO +: 2];
   assign pro      = cs_host_a_r[PRO_BIT];
   assign ubm      = cs_host_a_r[UBM_LO +: 4];
   assign auto_raw = ubm == 4'h4 || ubm == 4'hC || ubm == 4'h8;
   assign mode = cfg == 2'b01 ? UM_RAW :
                 cfg != 2'b10 ? UM_IGNORE :
                 !pro         ? UM_IU :
                 auto_raw     ? UM_RAW : UM_IGNORE;
   assign size_large = conf_r[CONF_SIZE_BIT] &&
                       !(cfg == 2'b10 && pro && ubm == 4'h8);
   assign ub_last    = size_large ? UB_LAST_LARGE : UB_LAST_SMALL;
   assign rd_last    = mode == UM_IU ? UB_LAST_LARGE : ub_last;

   assign st_mismatch = (st_r == UB_RAW && mode != UM_RAW) ||
                        ((st_r == UB_GAP || st_r == UB_UNIT) &&
                         mode != UM_IU);
   assign raw_byte = st_r == UB_RAW && sub.valid && bcnt_r == 3'h7;
   assign raw_full = raw_byte && waddr_r == ub_last;
   assign iu_done  = st_r == UB_UNIT && sub.valid &&
                     bcnt_r == IU_BITS_LAST;
   assign iu_byte  = iu_done && waddr_r <= UB_LAST_LARGE;
   assign q_full   = iu_done && iu_cnt_r == IU_Q_LAST;
   assign crc_bad  = q_full && !crc_ok(q_sh_r);
   assign zero_run_end = st_r == UB_GAP && sub.valid && !sub.user &&
                         zcnt_r == IU_ZERO_RUN && waddr_r != 7'h00;
   assign ub_swap   = (raw_full || zero_run_end) && !st_mismatch;
   assign mem_we    = (raw_byte || iu_byte) && !st_mismatch;
   assign mem_wdata = raw_byte ? {bsh_r, sub.user}
                               : {1'b1, bsh_r[5:0], sub.user};

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         st_r     <= UB_IDLE;
         bsh_r    <= 7'h00;
         bcnt_r   <= 3'h0;
         waddr_r  <= 7'h00;
         zcnt_r   <= 4'h0;
         iu_cnt_r <= 7'h00;
         q_sh_r   <= '0;
      end
      else if (st_mismatch || mode == UM_IGNORE)
         st_r <= UB_IDLE;
      else if (sub.valid)
      begin
         unique case (st_r)
            UB_IDLE:
            begin
               waddr_r  <= 7'h00;
               iu_cnt_r <= 7'h00;
               zcnt_r   <= 4'h0;
               if (mode == UM_IU)
                  st_r <= UB_GAP;
               else if (sf_z)
               begin
                  st_r   <= UB_RAW;
                  bsh_r  <= {6'h00, sub.user};
                  bcnt_r <= 3'h1;
               end
            end
            UB_RAW:
            begin
               bsh_r  <= {bsh_r[5:0], sub.user};
               bcnt_r <= bcnt_r + 3'h1;
               if (raw_byte)
                  waddr_r <= waddr_r + 7'h01;
               if (raw_full)
                  st_r <= UB_IDLE;
            end
            UB_GAP:
            begin
               if (sub.user)
               begin
                  st_r   <= UB_UNIT;
                  bcnt_r <= 3'h0;
               end
               else
               begin
                  if (zcnt_r != IU_ZERO_RUN)
                     zcnt_r <= zcnt_r + 4'h1;
                  if (zero_run_end)
                  begin
                     waddr_r  <= 7'h00;
                     iu_cnt_r <= 7'h00;
                  end
               end
            end
            UB_UNIT:
            begin
               bsh_r  <= {bsh_r[5:0], sub.user};
               bcnt_r <= bcnt_r + 3'h1;
               if (bcnt_r == 3'h0)
                  q_sh_r <= {q_sh_r[94:0], sub.user};
               if (iu_done)
               begin
                  st_r     <= UB_GAP;
                  zcnt_r   <= 4'h0;
                  iu_cnt_r <= q_full ? 7'h00 : iu_cnt_r + 7'h01;
                  if (iu_byte)
                     waddr_r <= waddr_r + 7'h01;
               end
            end
         endcase
      end
   end

   assign wbank_nxt = ub_swap ? ~wbank_r : wbank_r;

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         wbank_r <= 1'b0;
         q_buf_r <= '0;
      end
      else
      begin
         wbank_r <= wbank_nxt;
         if (q_full)
            q_buf_r <= q_sh_r[95:96-Q_PAY_BITS];
      end
   end

   // Read port follows the next address so back-to-back reads hold
   ub_mem mem_i (
      .clk_sys (clk_sys),
      .rst     (rst),
      .we      (mem_we),
      .waddr   (bank_addr(wbank_r, waddr_r)),
      .wdata   (mem_wdata),
      .raddr   (bank_addr(~wbank_nxt, ub_addr_nxt)),
      .rdata   (mem_q)
   );

   assign in_cs   = host.addr >= CS_BASE && host.addr <= CS_LAST;
   assign in_q    = host.addr >= REG_QSUB_BASE && host.addr <= REG_QSUB_LAST;
   assign cs_idx  = 5'(host.addr - CS_BASE);
   assign q_idx   = 4'(host.addr - REG_QSUB_BASE);
   assign cs_view = sel_r ? cs_host_b_r : cs_host_a_r;
   assign cs_byte = cs_view[{cs_idx, 3'b000} +: 8];
   assign q_hi    = 7'(7'h4F - {q_idx, 3'b000});
   assign q_byte  = q_buf_r[q_hi -: 8];
   assign rd_flags = host.rd && host.addr == REG_FLAGS;
   assign rd_ubd   = host.rd && host.addr == REG_UB_DATA;

   assign rd_mux = in_cs                     ? cs_byte :
                   in_q                      ? q_byte :
                   host.addr == REG_BUF_CONF ? conf_r :
                   host.addr == REG_CS_SWITCH ? {7'h00, sel_r} :
                   host.addr == REG_FLAGS    ? {5'h00, flags_r} :
                   host.addr == REG_MASK     ? mask_r :
                   host.addr == REG_UB_ADDR  ? {1'b0, ub_addr_r} :
                   host.addr == REG_UB_DATA  ? mem_q : 8'h00;

   assign ub_addr_nxt =
      host.wr && host.addr == REG_UB_ADDR ? host.wdata[6:0] :
      rd_ubd ? (ub_addr_r >= rd_last ? 7'h00 : ub_addr_r + 7'h01) :
      ub_addr_r;

   // read clears, a new event wins
   assign flags_nxt = (rd_flags ? 3'h0 : flags_r) |
      {crc_bad,
       ub_swap && mask_r[MASK_UB_BIT],
       cs_done && (!conf_r[CONF_FSEL_BIT] || cs_changed)};

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         conf_r    <= CONF_RESET;
         sel_r     <= 1'b0;
         mask_r    <= MASK_RESET;
         flags_r   <= FLAGS_RESET;
         ub_addr_r <= 7'h00;
         rd_data_r <= 8'h00;
         rd_ack_r  <= 1'b0;
      end
      else
      begin
         flags_r   <= flags_nxt;
         ub_addr_r <= ub_addr_nxt;
         rd_ack_r  <= host.rd;
         if (host.rd)
            rd_data_r <= rd_mux;
         if (host.wr && host.addr == REG_BUF_CONF)
            conf_r <= {4'h0, host.wdata[3:0]};
         if (host.wr && host.addr == REG_CS_SWITCH)
            sel_r <= host.wdata[0];
         if (host.wr && host.addr == REG_MASK)
            mask_r <= host.wdata;
      end
   end

   assign rd_data               = rd_data_r;
   assign rd_ack                = rd_ack_r;
   assign status_block_flag     = flags_r[FLAG_CSB_BIT];
   assign user_buffer_full_flag = flags_r[FLAG_UB_BIT];
   assign subcode_crc_fail_flag = flags_r[FLAG_CRC_BIT];

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence cs_read_s;
      host.rd && in_cs;
   endsequence
   sequence flag_read_s;
      host.rd && host.addr == REG_FLAGS;
   endsequence

   cs_window_a: assert property (cs_read_s |=> rd_ack &&
      rd_data == $past(cs_byte))
      else $error("status window byte wrong");
   cs_copy_a: assert property (cs_done |=>
      cs_host_b_r == $past(cs_new_b) && cs_host_a_r == $past(cs_work_a_r))
      else $error("status block not copied");
   ub_walk_a: assert property (rd_ubd && !host.wr |=>
      ub_addr_r == ($past(ub_addr_r) >= $past(rd_last) ? 7'h00 :
                    7'($past(ub_addr_r) + 7'h01)))
      else $error("user offset did not step");
   csb_every_a: assert property (
      cs_done && !conf_r[CONF_FSEL_BIT] |=> status_block_flag)
      else $error("status flag missing");
   csb_same_a: assert property (cs_done && conf_r[CONF_FSEL_BIT] &&
      !cs_changed && !status_block_flag |=> !status_block_flag)
      else $error("status flag on unchanged block");
   ignore_mode_a: assert property (mode == UM_IGNORE |-> !mem_we)
      else $error("user bits stored while ignored");
   ub_flag_a: assert property (
      ub_swap && mask_r[MASK_UB_BIT] |=> user_buffer_full_flag ##0
      wbank_r != $past(wbank_r))
      else $error("user flag or swap missing");
   unit_byte_a: assert property (mem_we && st_r == UB_UNIT |->
      mem_wdata[7])
      else $error("unit byte lacks leading one");
   zero_run_a: assert property (zero_run_end && !st_mismatch |=>
      waddr_r == 7'h00 && wbank_r != $past(wbank_r))
      else $error("message not committed");
   crc_hold_a: assert property (
      subcode_crc_fail_flag && !rd_flags |=> subcode_crc_fail_flag)
      else $error("check flag dropped early");
   crc_clear_a: assert property (
      flag_read_s ##0 !crc_bad |=> !subcode_crc_fail_flag)
      else $error("check flag not cleared");
endmodule
`default_nettype wire

// [spdif_src_model.sv]
`timescale 1ns/1ps
`default_nettype none
module spdif_src_model
   import spdif_rx_pkg::*;
(
   input  wire logic         clk_sys,
   input  wire logic         rst,
   input  wire logic         go,
   input  wire logic         inv,
   input  wire logic [1:0]   gap,
   input  wire logic [191:0] cs_a,
   input  wire logic [191:0] cs_b,
   input  wire logic [383:0] ubits,
   output var  subframe_t    sub,
   output var  logic         busy
);
   logic [8:0] s;
   logic [1:0] w;
   logic [7:0] pre;

   assign pre = (s == 9'd0) ? PRE_Z : (s[0] ? PRE_Y : PRE_X);

   always @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         sub <= '0;
         busy <= 1'b0;
         s <= '0;
         w <= '0;
      end
      else if (busy && w == 2'd0)
      begin
         sub <= '{valid: 1'b1, preamble: inv ? ~pre : pre,
                  user: ubits[383 - s],
                  status: s[0] ? cs_b[s[8:1]] : cs_a[s[8:1]]};
         w <= gap;
         s <= s + 9'd1;
         if (s == 9'd383)
            busy <= 1'b0;
      end
      else
      begin
         // Idle fields wander so stale values are never trusted
         sub.valid <= 1'b0;
         sub.preamble <= ~sub.preamble;
         sub.user <= ~sub.user;
         sub.status <= ~sub.status;
         if (go && !busy)
         begin
            busy <= 1'b1;
            s <= '0;
            w <= '0;
         end
         else if (busy)
            w <= w - 2'd1;
      end
   end
endmodule
`default_nettype wire

// [spdif_rx_buffers_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module spdif_rx_buffers_tb import spdif_rx_pkg::*;;
   logic         clk_sys = 1'b0;
   logic         rst = 1'b1;
   subframe_t    sub;
   host_req_t    host = '0;
   logic [7:0]   rd_data;
   logic         rd_ack, csb_f, ub_f, crc_f, busy;
   logic         go = 1'b0, inv = 1'b0;
   logic [1:0]   gap = 2'd0;
   logic [191:0] cs_a = '0, cs_b = '0;
   logic [383:0] ubits = '0;
   logic [7:0]   expq[$];
   logic [31:0]  x = 32'h2B77;
   logic [95:0]  q;
   logic [7:0]   r;
   logic [767:0] iub;
   logic [1151:0] iu_s;
   int           errors = 0, check_count = 0, i, j;

   always #4 clk_sys = ~clk_sys;

   spdif_rx_buffers dut_u (.clk_sys(clk_sys), .rst(rst), .sub(sub),
      .host(host), .rd_data(rd_data), .rd_ack(rd_ack),
      .status_block_flag(csb_f), .user_buffer_full_flag(ub_f),
      .subcode_crc_fail_flag(crc_f));

   spdif_src_model src_u (.clk_sys(clk_sys), .rst(rst), .go(go),
      .inv(inv), .gap(gap), .cs_a(cs_a), .cs_b(cs_b), .ubits(ubits),
      .sub(sub), .busy(busy));

   function logic [31:0] xs();
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      return x;
   endfunction

   // Check word over the payload, first bit first
   function logic [15:0] crc16(input logic [79:0] d);
      logic [15:0] c;
      c = 16'h0000;
      for (int k = 79; k >= 0; k--)
         c = {c[14:0], 1'b0} ^ ((c[15] ^ d[k]) ? Q_CRC_POLY : 16'h0000);
      return c;
   endfunction

   task chk(input logic [7:0] seen, input logic [7:0] exp, input string nm);
      check_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task stop_test();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      host <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk_sys);
      host <= '0;
   endtask

   task rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      expq.push_back(e);
      host <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk_sys);
      host <= '0;
   endtask

   // One whole 192-frame block, subframe spacing drawn at random
   task block();
      @(posedge clk_sys);
      go <= 1'b1;
      gap <= 2'(xs());
      @(posedge clk_sys);
      go <= 1'b0;
      @(negedge clk_sys);
      for (j = 0; j < 3000 && busy !== 1'b0; j++)
         @(negedge clk_sys);
      if (j == 3000)
      begin
         errors++;
         $display("Error source stuck busy");
         stop_test();
      end
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask

   always @(negedge clk_sys)
   begin
      if (rd_ack === 1'b1)
         chk(rd_data, (expq.size() > 0) ? expq.pop_front() : 8'hXX,
             "rd_data");
   end

   initial
   begin
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      rd(REG_FLAGS, 8'h00);
      rd(REG_BUF_CONF, CONF_RESET);
      rd(CS_BASE, 8'h00);
      rd(8'h00, 8'h00);
      for (i = 0; i < 12; i++)
      begin
         ubits[32*i +: 32] = xs();
         if (i < 6)
         begin
            cs_a[32*i +: 32] = xs();
            cs_b[32*i +: 32] = xs();
         end
      end
      // Consumer status so automatic mode picks information units
      cs_a[0] = 1'b0;
      // Buffered user bits, 384-bit size, full flag unmasked
      wr(REG_BUF_CONF, 8'h02);
      wr(REG_MASK, 8'h02);
      block();
      chk({7'h0, csb_f}, 8'h01, "status_block_flag");
      chk({7'h0, ub_f}, 8'h01, "user_buffer_full_flag");
      chk({7'h0, crc_f}, 8'h00, "subcode_crc_fail_flag");
      rd(REG_FLAGS, 8'h03);
      rd(REG_FLAGS, 8'h00);
      wr(CS_BASE, 8'hFF);
      for (i = 0; i < 24; i++)
         rd(CS_BASE + 8'(i), cs_a[8*i +: 8]);
      wr(REG_CS_SWITCH, 8'h01);
      for (i = 0; i < 24; i++)
         rd(CS_BASE + 8'(i), cs_b[8*i +: 8]);
      // One read past the last byte shows the wrap
      wr(REG_UB_ADDR, 8'h00);
      for (i = 0; i < 49; i++)
         rd(REG_UB_DATA, ubits[383 - 8*(i % 48) -: 8]);
      // Flag only on change, user bits ignored, inverted preambles
      wr(REG_BUF_CONF, 8'h08);
      inv <= 1'b1;
      block();
      rd(REG_FLAGS, 8'h00);
      cs_a[3] = ~cs_a[3];
      block();
      rd(REG_FLAGS, 8'h01);
      wr(REG_CS_SWITCH, 8'h00);
      rd(CS_BASE, cs_a[7:0]);
      // 96 units, each after one stuffing zero; check word left uninverted
      q = {xs(), xs(), xs()};
      q[15:0] = crc16(q[95:16]);
      iu_s = '0;
      for (i = 0; i < 96; i++)
      begin
         r = {1'b1, q[95 - i], 6'(xs())};
         iub[8*i +: 8] = r;
         iu_s[1150 - 9*i -: 8] = r;
      end
      wr(REG_BUF_CONF, 8'h04);
      for (i = 0; i < 3; i++)
      begin
         ubits = iu_s[1151 - 384*i -: 384];
         block();
      end
      chk({7'h0, crc_f}, 8'h01, "subcode_crc_fail_flag");
      rd(REG_FLAGS, 8'h07);
      rd(REG_FLAGS, 8'h00);
      wr(REG_UB_ADDR, 8'h00);
      for (i = 0; i < 96; i++)
         rd(REG_UB_DATA, iub[8*i +: 8]);
      for (i = 0; i < 10; i++)
         rd(REG_QSUB_BASE + 8'(i), q[95 - 8*i -: 8]);
      repeat (4) @(posedge clk_sys);
      stop_test();
   end

   initial
   begin
      repeat (20000) @(posedge clk_sys);
      errors++;
      $display("Error watchdog expired");
      stop_test();
   end
endmodule
`default_nettype wire
